/* File: vdcfg_core.v */
/*
 * video decoder input configuration: register port, field-aligned setting
 * shadow, channel settle tracking, temporal decimation, flip and gain control.
 * assumes field start, parity, line format, burst and converter overflow come
 * from the decoder on the same clock as single-cycle pulses or levels.
 */
`timescale 1ns/1ps
`include "vdcfg_defs.vh"

module vdcfg_core #(
    parameter CNT_W = 7
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // register port
    input  wire [3:0]       reg_addr,
    input  wire [15:0]      reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [15:0]      reg_rdata,
    // decoder timing and status
    input  wire             field_start,
    input  wire             field_even,
    input  wire             lines_625,
    input  wire             burst_present,
    input  wire             adc_overflow,
    input  wire             capture_run,
    // decoder controls
    output reg  [1:0]       select_input_channel,
    output reg              mono_notch_bypass,
    output reg              notch_enable,
    output reg              chroma_adc_power,
    output reg  [1:0]       interlace_mode,
    output reg              half_line_shift,
    output reg              chroma_gain_enable,
    output reg              main_gain_disable,
    output reg              adaptive_gain_select,
    output reg  [3:0]       adc_reference,
    output reg              colour_decode_on,
    output reg              vertical_flip_active,
    // capture path
    output reg              field_keep,
    output reg              image_valid
);

    function [CNT_W:0] acc_add;
        input [CNT_W:0] a;
        input [CNT_W-1:0] b;
        begin
            acc_add = a + {1'b0, b};
        end
    endfunction

    // software side registers
    reg [1:0]       chan_q;
    reg [4:0]       filt_q;
    reg [2:0]       gain_q;
    reg [7:0]       dcnt_q;
    reg             dunit_q;
    reg             dpar_q;
    reg             flip_q;
    reg             flip_apply_q;
    reg             dec_wr_q;

    // field-synchronised state
    reg [2:0]       settle_q;
    reg [CNT_W:0]   acc_q;
    reg [CNT_W:0]   acc_d;
    reg             frame_drop_q;
    reg             started_q;
    reg             drop_d;
    wire [CNT_W-1:0] group_size;
    wire [CNT_W-1:0] drop_step;
    wire            started_w;

    assign group_size = lines_625 ? `VDCFG_GROUP_625 : `VDCFG_GROUP_525;
    // counts above the group drop every unit and keep the sum from overflowing
    assign drop_step = (dcnt_q > {1'b0, group_size}) ? group_size : dcnt_q[CNT_W-1:0];
    assign started_w = started_q & ~dec_wr_q;

    // register writes
    always @(posedge clk) begin
        if (rst) begin
            chan_q       <= `VDCFG_RST_CHANNEL;
            filt_q       <= `VDCFG_RST_FILTER;
            gain_q       <= `VDCFG_RST_GAIN;
            dcnt_q       <= 8'h00;
            dunit_q      <= 1'b0;
            dpar_q       <= 1'b0;
            flip_q       <= `VDCFG_RST_FLIP;
            flip_apply_q <= 1'b0;
            dec_wr_q     <= 1'b0;
        end else begin
            flip_apply_q <= 1'b0;
            // restarts the drop phase, so a new start parity is honoured
            dec_wr_q     <= reg_wr && (reg_addr == `VDCFG_REG_DECIM);
            if (reg_wr) begin
                case (reg_addr)
                    `VDCFG_REG_CHANNEL: chan_q <= reg_wdata[1:0];
                    `VDCFG_REG_FILTER:  filt_q <= reg_wdata[4:0];
                    `VDCFG_REG_GAIN:    gain_q <= reg_wdata[2:0];
                    `VDCFG_REG_DECIM: begin
                        dcnt_q  <= reg_wdata[`VDCFG_DEC_COUNT_LSB +: 8];
                        dunit_q <= reg_wdata[`VDCFG_DEC_UNIT_BIT];
                        dpar_q  <= reg_wdata[`VDCFG_DEC_PAR_BIT];
                    end
                    `VDCFG_REG_FLIP:    flip_q <= reg_wdata[0];
                    // window apply only honoured while stopped
                    `VDCFG_REG_APPLY:   flip_apply_q <= ~capture_run;
                    default: ;
                endcase
            end
        end
    end

    // flip latches only on window apply
    always @(posedge clk) begin
        if (rst)
            vertical_flip_active <= `VDCFG_RST_FLIP;
        else if (flip_apply_q)
            vertical_flip_active <= flip_q;
    end

    // filter settings except the colour kill bit, and gain settings, move together at a field start
    always @(posedge clk) begin
        if (rst) begin
            select_input_channel <= `VDCFG_RST_CHANNEL;
            mono_notch_bypass    <= 1'b0;
            notch_enable         <= 1'b1;
            chroma_adc_power     <= 1'b0;
            interlace_mode       <= `VDCFG_ILACE_NON;
            chroma_gain_enable   <= 1'b1;
            main_gain_disable    <= 1'b0;
            adaptive_gain_select <= 1'b0;
        end else if (field_start) begin
            select_input_channel <= chan_q;
            mono_notch_bypass    <= filt_q[`VDCFG_FLT_NOTCH_BIT];
            // composite forces notch on and chroma converter off
            notch_enable         <= filt_q[`VDCFG_FLT_COMP_BIT] | ~filt_q[0];
            chroma_adc_power     <= ~filt_q[`VDCFG_FLT_COMP_BIT];
            interlace_mode       <= filt_q[`VDCFG_FLT_ILACE_LSB +: 2];
            chroma_gain_enable   <= gain_q[`VDCFG_GN_CHROMA_BIT];
            main_gain_disable    <= gain_q[`VDCFG_GN_MAIN_BIT];
            adaptive_gain_select <= gain_q[`VDCFG_GN_ADAPT_BIT];
        end
    end

    // second field moved half a line in field-aligned mode
    always @(posedge clk) begin
        if (rst)
            half_line_shift <= 1'b0;
        else
            half_line_shift <= (interlace_mode == `VDCFG_ILACE_ALIGN) & field_even;
    end

    // colour killer
    always @(posedge clk) begin
        if (rst)
            colour_decode_on <= 1'b1;
        else
            colour_decode_on <= ~filt_q[`VDCFG_FLT_KILL_BIT] | burst_present;
    end

    // adaptive reference: steps up on overflow, saturates, resets when not adaptive
    always @(posedge clk) begin
        if (rst)
            adc_reference <= 4'h0;
        else if (!adaptive_gain_select || main_gain_disable)
            adc_reference <= 4'h0;
        else if (adc_overflow && adc_reference != `VDCFG_REF_MAX)
            adc_reference <= adc_reference + 4'h1;
    end

    // settle counter; a channel change invalidates the next fields
    always @(posedge clk) begin
        if (rst)
            settle_q <= `VDCFG_SETTLE_FIELDS;
        else if (field_start && chan_q != select_input_channel)
            settle_q <= `VDCFG_SETTLE_FIELDS;
        else if (field_start && settle_q != 3'h0)
            settle_q <= settle_q - 3'h1;
    end

    // even drop spreading: accumulate drop count per unit, drop on wrap.
    // frames are judged at their first field, the second follows it.
    always @* begin
        acc_d  = acc_add(acc_q, drop_step);
        drop_d = 1'b0;
        if (acc_d >= {1'b0, group_size}) begin
            acc_d  = acc_d - {1'b0, group_size};
            drop_d = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            acc_q        <= {(CNT_W+1){1'b0}};
            frame_drop_q <= 1'b0;
            started_q    <= 1'b0;
            field_keep   <= 1'b0;
            image_valid  <= 1'b0;
        end else begin
            // a new decimation setting restarts the spreading phase
            if (dec_wr_q) begin
                acc_q     <= {(CNT_W+1){1'b0}};
                started_q <= 1'b0;
            end
            if (field_start) begin
                // the fourth field start after a switch brings a settled image
                image_valid <= (settle_q <= 3'h1) && (chan_q == select_input_channel);
                if (dcnt_q == 8'h00) begin
                    field_keep <= 1'b1;
                    acc_q      <= {(CNT_W+1){1'b0}};
                    started_q  <= 1'b0;
                end else if (!started_w && field_even != dpar_q) begin
                    field_keep <= 1'b1;
                end else if (!started_w) begin
                    // the first unit of the chosen parity is the first one dropped
                    started_q    <= 1'b1;
                    acc_q        <= {(CNT_W+1){1'b0}};
                    frame_drop_q <= 1'b1;
                    field_keep   <= 1'b0;
                end else if (dunit_q) begin
                    acc_q      <= acc_d;
                    field_keep <= ~drop_d;
                end else if (field_even == dpar_q) begin
                    acc_q        <= acc_d;
                    frame_drop_q <= drop_d;
                    field_keep   <= ~drop_d;
                end else begin
                    field_keep <= ~frame_drop_q;
                end
            end
        end
    end

    // read data, one cycle after the strobe
    always @(posedge clk) begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            case (reg_addr)
                `VDCFG_REG_CHANNEL: reg_rdata <= {14'h0000, chan_q};
                `VDCFG_REG_FILTER:  reg_rdata <= {11'h000, filt_q};
                `VDCFG_REG_GAIN:    reg_rdata <= {13'h0000, gain_q};
                `VDCFG_REG_DECIM:   reg_rdata <= {6'h00, dpar_q, dunit_q, dcnt_q};
                `VDCFG_REG_FLIP:    reg_rdata <= {15'h0000, flip_q};
                `VDCFG_REG_STATUS:  reg_rdata <= {8'h00, adc_reference, colour_decode_on,
                                                  image_valid, field_keep,
                                                  vertical_flip_active};
                `VDCFG_REG_ACTIVE:  reg_rdata <= {8'h00, interlace_mode, half_line_shift,
                                                  settle_q, select_input_channel};
                default:            reg_rdata <= 16'h0000;
            endcase
        end
    end

endmodule // vdcfg_core

/* File: vdcfg_defs.vh */
/*
 * constants for the video decoder input configuration block.
 * assumes one 100 MHz clock, synchronous active-high reset, plain register port.
 */
// Functional notes
// - route selected channel one to four
// - mark images invalid four fields after switch
// - notch on at zero, bypass at one
// - notch enabled after initialization
// - interlace select: non, interlaced, field aligned
// - field aligned shifts second field half line
// - chroma gain adapts when enabled
// - main gain active at zero, off at one
// - adaptive gain raises reference on overflow
// - colour killer suppresses colour without burst
// - no decimation delivers every image
// - decimation unit: frames zero, fields one
// - decimation starts odd zero, even one
// - drop count out of fifty or sixty
// - drops spread evenly across group
// - flip selects top-down or bottom-up line order
// - flip defaults to one
// - flip takes effect on window apply
// - composite mode: chroma converter off, notch on
`ifndef VDCFG_DEFS_VH
`define VDCFG_DEFS_VH

`define VDCFG_REG_CHANNEL    4'h0
`define VDCFG_REG_FILTER     4'h1
`define VDCFG_REG_GAIN       4'h2
`define VDCFG_REG_DECIM      4'h3
`define VDCFG_REG_FLIP       4'h4
`define VDCFG_REG_APPLY      4'h5
`define VDCFG_REG_STATUS     4'h6
`define VDCFG_REG_ACTIVE     4'h7

// filter register fields
`define VDCFG_FLT_NOTCH_BIT  0
`define VDCFG_FLT_ILACE_LSB  1
`define VDCFG_FLT_COMP_BIT   3
`define VDCFG_FLT_KILL_BIT   4
// gain register fields
`define VDCFG_GN_CHROMA_BIT  0
`define VDCFG_GN_MAIN_BIT    1
`define VDCFG_GN_ADAPT_BIT   2
// decimation register fields
`define VDCFG_DEC_COUNT_LSB  0
`define VDCFG_DEC_UNIT_BIT   8
`define VDCFG_DEC_PAR_BIT    9

`define VDCFG_RST_CHANNEL    2'h0
`define VDCFG_RST_FILTER     5'h18
`define VDCFG_RST_GAIN       3'h1
`define VDCFG_RST_FLIP       1'h1

`define VDCFG_ILACE_NON      2'h0
`define VDCFG_ILACE_INT      2'h1
`define VDCFG_ILACE_ALIGN    2'h2

`define VDCFG_SETTLE_FIELDS  3'h4
`define VDCFG_GROUP_625      7'h32
`define VDCFG_GROUP_525      7'h3c
`define VDCFG_REF_MAX        4'hf

`endif

/* File: vdcfg_cam_model.sv */
/* camera and decoder timing model: field pulses, parity, burst and overflow.
   assumes the block's clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module vdcfg_cam_model #(
    parameter FLD = 20
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // scenario controls
    input  wire logic mono_src,
    input  wire logic hot_src,
    // decoder timing and status
    output logic      field_start,
    output logic      field_even,
    output logic      burst_present,
    output logic      adc_overflow
);
    int cnt;
    // short fields keep long decimation groups cheap to run
    always @(posedge clk) begin
        cnt <= (rst || cnt == FLD - 1) ? 0 : cnt + 1;
        field_start <= !rst && cnt == FLD - 1;
        if (rst)
            field_even <= 1'b1;
        else if (cnt == FLD - 1)
            field_even <= !field_even;
        burst_present <= !mono_src;
        adc_overflow <= hot_src && cnt == 8;
    end
endmodule // vdcfg_cam_model

/* File: vdcfg_core_properties.sv */
/* checker for vdcfg_core: field-aligned updates, gain, colour, settle and flip.
   assumes a bind to vdcfg_core, one clock, synchronous active-high rst. */
`timescale 1ns/1ps
module vdcfg_core_chk (
    // clock, reset and decoder timing
    input wire logic       clk, rst, field_start, field_even, burst_present,
    input wire logic       adc_overflow, capture_run,
    // decoder controls and capture path
    input wire logic [1:0] select_input_channel, interlace_mode,
    input wire logic       mono_notch_bypass, notch_enable, chroma_adc_power,
    input wire logic       half_line_shift, main_gain_disable, adaptive_gain_select,
    input wire logic       colour_decode_on, vertical_flip_active, field_keep, image_valid,
    input wire logic [3:0] adc_reference
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] chan_q;
    logic [2:0] settle_q;
    // field starts seen since the channel last moved, saturating
    always @(posedge clk) begin
        chan_q <= select_input_channel;
        if (rst)
            settle_q <= 3'h0;
        else if (select_input_channel != chan_q)
            settle_q <= {2'h0, field_start};
        else if (field_start && settle_q != 3'h7)
            settle_q <= settle_q + 3'h1;
    end
    sequence s_ovf;
        adaptive_gain_select && !main_gain_disable && adc_overflow && !field_start
            && adc_reference != 4'hf;
    endsequence
    chk_notch_field: assert property (!$stable(notch_enable) && !$past(rst) |-> $past(field_start))
        else $error("notch control moved away from a field start");
    chk_notch_level: assert property (notch_enable == (!chroma_adc_power || !mono_notch_bypass))
        else $error("notch state disagrees with source mode");
    chk_half_line: assert property (half_line_shift == ($past(interlace_mode) == 2'h2 && $past(field_even)))
        else $error("half line shift wrong");
    chk_colour_burst: assert property ($past(burst_present) |-> colour_decode_on)
        else $error("colour suppressed with burst present");
    chk_ref_clear: assert property (!adaptive_gain_select && !$past(adaptive_gain_select) |-> adc_reference == 4'h0)
        else $error("reference raised without adaptive gain");
    chk_ref_step: assert property (s_ovf |=> adc_reference == $past(adc_reference) + 4'h1)
        else $error("reference not raised on overflow");
    chk_keep_field: assert property (!$stable(field_keep) && !$past(rst) |-> $past(field_start))
        else $error("keep decision moved inside a field");
    chk_valid_settle: assert property (image_valid |-> settle_q >= 3'h4)
        else $error("image valid before four fields settled");
    chk_flip_stopped: assert property (!$stable(vertical_flip_active) && !$past(rst) |-> !$past(capture_run, 2))
        else $error("flip changed while capture running");
endmodule // vdcfg_core_chk
bind vdcfg_core vdcfg_core_chk chk_u (.*);

/* File: tb_video_decoder_input_config.sv */
/* testbench for vdcfg_core: register driver with read scoreboard and camera model.
   assumes a 100 MHz clock and the model's 20-cycle fields. */
`timescale 1ns/1ps
`include "vdcfg_defs.vh"
module tb_video_decoder_input_config;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
    logic lines_625 = 1'b1, capture_run = 1'b0, mono_src = 1'b0, hot_src = 1'b0;
    logic [3:0]  reg_addr = 4'h0, adc_reference;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic [1:0]  select_input_channel, interlace_mode;
    logic        mono_notch_bypass, notch_enable, chroma_adc_power, half_line_shift;
    logic        chroma_gain_enable, main_gain_disable, adaptive_gain_select;
    logic        colour_decode_on, vertical_flip_active, field_keep, image_valid;
    logic        field_start, field_even, burst_present, adc_overflow;
    logic [7:0]  c;
    logic [31:0] exp_q[$];
    int fail_count = 0, n_compared = 0, kept, kept_even, g, r;
    vdcfg_core dut_u (.*);
    vdcfg_cam_model cam_u (.*);
    initial forever #5 clk = ~clk;
    // a gap cycle between strobes keeps one assignment per signal per step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        exp_q.push_back({m, e});
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic chk_rd(input logic [31:0] n);
        n_compared++;
        if ((reg_rdata & n[31:16]) !== n[15:0]) begin
            fail_count++;
            $display("CHECK FAILED %0t read %h expected %h", $time, reg_rdata, n[15:0]);
        end
    endtask
    task automatic chk_num(input int got, input int e);
        n_compared++;
        if (got != e) begin
            fail_count++;
            $display("CHECK FAILED %0t count %0d expected %0d", $time, got, e);
        end
    endtask
    task automatic fld;
        do @(posedge clk); while (field_start !== 1'b1);
        repeat (2) @(posedge clk);
    endtask
    // counts kept fields over n fields, starting at a field of parity p
    task automatic count(input int n, input logic p);
        kept = 0;
        kept_even = 0;
        do @(posedge clk); while (!(field_start === 1'b1 && field_even === p));
        repeat (n) begin
            repeat (2) @(posedge clk);
            kept += (field_keep === 1'b1);
            kept_even += (field_keep === 1'b1 && field_even === 1'b1);
            do @(posedge clk); while (field_start !== 1'b1);
        end
    endtask
    always @(posedge clk) begin
        rd_q <= reg_rd;
        if (rd_q)
            chk_rd(exp_q.pop_front());
    end
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        wrap_up;
    end
    initial begin
        r = $urandom(43);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        capture_run <= 1'b1;
        rd(`VDCFG_REG_FILTER, 16'h1f, 16'h18);
        rd(`VDCFG_REG_FLIP, 16'h1, 16'h1);
        chk_num({mono_notch_bypass, notch_enable, chroma_adc_power} === 3'b010, 1);
        r = $urandom_range(15, 8);
        wr(r[3:0], 16'($urandom));
        rd(r[3:0], 16'hffff, 16'h0);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            wr(`VDCFG_REG_FILTER, 16'(16 | (i << 1) | (i & 1)));
            fld;
            rd(`VDCFG_REG_ACTIVE, 16'hc0, 16'(i << 6));
            chk_num({mono_notch_bypass, notch_enable} === {i[0], !i[0]}, 1);
            chk_num(chroma_adc_power === 1'b1, 1);
        end
        mono_src <= 1'b1;
        fld;
        rd(`VDCFG_REG_STATUS, 16'h8, 16'h0);
        wr(`VDCFG_REG_FILTER, 16'h4);
        fld;
        rd(`VDCFG_REG_STATUS, 16'h8, 16'h8);
        mono_src <= 1'b0;
        wr(`VDCFG_REG_GAIN, 16'h5);
        hot_src <= 1'b1;
        repeat (20) fld;
        chk_num({chroma_gain_enable, adaptive_gain_select} === 2'b11, 1);
        chk_num(main_gain_disable === 1'b0, 1);
        rd(`VDCFG_REG_STATUS, 16'hf0, 16'hf0);
        wr(`VDCFG_REG_GAIN, 16'h0);
        repeat (2) fld;
        chk_num({chroma_gain_enable, adaptive_gain_select} === 2'b00, 1);
        rd(`VDCFG_REG_STATUS, 16'hf0, 16'h0);
        hot_src <= 1'b0;
        $display("filter and gain done");
        wr(`VDCFG_REG_CHANNEL, 16'h2);
        fld;
        rd(`VDCFG_REG_ACTIVE, 16'h3, 16'h2);
        repeat (3) fld;
        rd(`VDCFG_REG_STATUS, 16'h4, 16'h0);
        fld;
        rd(`VDCFG_REG_STATUS, 16'h4, 16'h4);
        wr(`VDCFG_REG_FLIP, 16'h0);
        wr(`VDCFG_REG_APPLY, 16'h0);
        fld;
        rd(`VDCFG_REG_STATUS, 16'h1, 16'h1);
        capture_run <= 1'b0;
        wr(`VDCFG_REG_APPLY, 16'h0);
        fld;
        rd(`VDCFG_REG_STATUS, 16'h1, 16'h0);
        capture_run <= 1'b1;
        $display("channel and flip done");
        for (int l = 0; l < 2; l++) begin
            lines_625 <= l[0];
            g = l ? 50 : 60;
            for (int p = 0; p < 2; p++) begin
                wr(`VDCFG_REG_DECIM, {6'h0, p[0], 1'b1, 8'(g / 2)});
                repeat (2) count(g, p[0]);
                chk_num(kept, g / 2);
                chk_num(kept_even, p ? 0 : g / 2);
            end
            c = 8'($urandom_range(g));
            wr(`VDCFG_REG_DECIM, {8'h0, c});
            repeat (2) count(2 * g, 1'b0);
            chk_num(kept, 2 * (g - c));
        end
        wr(`VDCFG_REG_DECIM, 16'h0);
        count(50, 1'b0);
        chk_num(kept, 50);
        $display("decimation done");
        wrap_up;
    end
endmodule // tb_video_decoder_input_config
